/* verilog/fsef_regs.vh */
// Register map, field positions and reset values of the flash
// status and error flag block.
// Assumes a 32-bit APB with byte addresses; each register is one word.
`ifndef FSEF_REGS_VH
`define FSEF_REGS_VH

// Register indices; byte address is four times the index
`define FSEF_IDX_MODCFG 6'h04
`define FSEF_IDX_ERRCFG 6'h05
`define FSEF_IDX_STAT 6'h06
`define FSEF_IDX_ERRSTAT 6'h07

// Module configuration fields
`define FSEF_MODCFG_IGN_SF_BIT 4
`define FSEF_MODCFG_FDF_BIT 1

// Error interrupt configuration fields
`define FSEF_ERRCFG_DF_BIT 1
`define FSEF_ERRCFG_SF_BIT 0

// Command status fields
`define FSEF_STAT_CC_BIT 7
`define FSEF_STAT_ACC_BIT 5
`define FSEF_STAT_PV_BIT 4
`define FSEF_STAT_BUSY_BIT 3
`define FSEF_STAT_RSVD_BIT 2
`define FSEF_STAT_CS_HI 1
`define FSEF_STAT_CS_LO 0

// Error status fields
`define FSEF_ERRSTAT_DF_BIT 1
`define FSEF_ERRSTAT_SF_BIT 0

// Reset values
`define FSEF_MODCFG_RST 8'h00
`define FSEF_ERRCFG_RST 8'h00
`define FSEF_STAT_RST 8'h80
`define FSEF_ERRSTAT_RST 8'h00
`define FSEF_CS_RST 2'h0

`endif

/* verilog/fsef_flag.v */
// Sticky event flag, set by hardware and cleared by software.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/10ps

module fsef_flag (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Event and software clear
    input wire set,
    input wire clr,
    // Flag state
    output wire flag
);

reg flag_q;
reg flag_d;

// Set beats clear so an event in the clearing cycle is kept
always @*
begin
    flag_d = flag_q;
    if (set)
        flag_d = 1'b1;
    else if (clr)
        flag_d = 1'b0;
end

// Flag storage
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
        flag_q <= 1'b0;
    else
        flag_q <= flag_d;
end

assign flag = flag_q;

endmodule // fsef_flag

/* verilog/fsef_top.v */
// Status, error flag and error interrupt logic of a flash controller.
// Assumes the command sequencer and array read path run on CLK and
// deliver one-cycle event pulses; software reaches the registers by APB.
//
// How it works
// RL1: Double-fault flag with its enable set requests the error interrupt.
// RL2: Single-fault flag with its enable set requests the error interrupt.
// RL3: Command-complete reads 1 when done; writing 1 clears it and launches.
// RL4: Sequence violation or illegal command sets access error; blocks launch.
// RL5: Access error clears on written 1 only; written 0 leaves it.
// RL6: Protected program or erase sets protection violation; clears on 1.
// RL7: Protection violation refuses new sequences and command launches.
// RL8: Busy reads 1 while a command executes, when command-complete is 0.
// RL9: Status bit 2 is reserved and always reads 0.
// RL10: Completion status bits show errors from command or reset sequence.
// RL11: Only complete, access and protection bits of status take writes.
// RL12: Status reset value may change after a reset-sequence double fault.
// RL13: Array double fault or read of a busy block sets double-fault.
// RL14: Double-fault flag clears only on a written 1.
// RL15: Unless ignored, corrected single fault or busy-block read sets flag.
// RL16: Single-fault flag clears only on a written 1.
// RL17: Ignore-single-fault suppresses single-fault reports and interrupt.
// RL18: Force-double-fault makes every read set double-fault; no result update.
// RL19: Interrupt is OR of each fault flag ANDed with its enable.
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`include "fsef_regs.vh"

module fsef_top (
    // Clock and reset
    input wire CLK,
    input wire RST_N,
    // APB slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [3:0] PSTRB,
    output wire [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    // Command sequencer events
    input wire CMD_DONE,
    input wire [1:0] CMD_ERR,
    input wire SEQ_VIOL,
    input wire ILLEGAL_CMD,
    input wire PROT_VIOL,
    input wire INIT_DONE,
    input wire [1:0] INIT_ERR,
    // Command sequencer control
    output wire CMD_LAUNCH,
    output wire SEQ_START_OK,
    // Array read path
    input wire ARRAY_RD,
    input wire RD_SFAULT,
    input wire RD_DFAULT,
    input wire RD_BLK_BUSY,
    output wire ECC_UPDATE,
    // Configuration seen by the read path
    output wire IGNORE_SF,
    output wire FORCE_DF,
    // Error interrupt
    output wire ERR_IRQ
);

// Address decode
wire addr_ok;
wire hit_modcfg;
wire hit_errcfg;
wire hit_stat;
wire hit_errstat;
wire hit_any;
wire acc_phase;
wire wr_en;
wire rd_setup;

// Register state
reg [7:0] modcfg_q;
reg [7:0] modcfg_d;
reg [1:0] errcfg_q;
reg [1:0] errcfg_d;
reg busy_q;
reg busy_d;
reg [1:0] cstat_q;
reg [1:0] cstat_d;
reg launch_q;
reg ecc_upd_q;
reg [31:0] prdata_q;
reg [31:0] prdata_d;
reg [7:0] rd_byte;

// Flag wiring
wire acc_flag;
wire pv_flag;
wire df_flag;
wire sf_flag;
wire acc_set;
wire pv_set;
wire df_set;
wire sf_set;
wire acc_clr;
wire pv_clr;
wire df_clr;
wire sf_clr;
wire launch;
wire cmd_end;
wire ign_sf;
wire force_df;
wire [7:0] stat_byte;
wire [7:0] errstat_byte;

// Word aligned decode of the four register slots
assign addr_ok = (PADDR[1:0] == 2'h0);
assign hit_modcfg = addr_ok && (PADDR[7:2] == `FSEF_IDX_MODCFG);
assign hit_errcfg = addr_ok && (PADDR[7:2] == `FSEF_IDX_ERRCFG);
assign hit_stat = addr_ok && (PADDR[7:2] == `FSEF_IDX_STAT);
assign hit_errstat = addr_ok && (PADDR[7:2] == `FSEF_IDX_ERRSTAT);
assign hit_any = hit_modcfg | hit_errcfg | hit_stat | hit_errstat;

// Writes land only in the access phase; data sits in the low byte lane
assign acc_phase = PSEL & PENABLE;
assign wr_en = acc_phase & PWRITE & PSTRB[0];
assign rd_setup = PSEL & ~PENABLE & ~PWRITE;

// Zero wait states; an unmapped word answers with an error
assign PREADY = 1'b1;
assign PSLVERR = acc_phase & ~hit_any;

// Configuration fields
assign ign_sf = modcfg_q[`FSEF_MODCFG_IGN_SF_BIT];
assign force_df = modcfg_q[`FSEF_MODCFG_FDF_BIT];

// Module configuration: only the two fault controls are stored
always @*
begin
    modcfg_d = modcfg_q;
    if (wr_en && hit_modcfg)
    begin
        modcfg_d = `FSEF_MODCFG_RST;
        modcfg_d[`FSEF_MODCFG_IGN_SF_BIT] = PWDATA[`FSEF_MODCFG_IGN_SF_BIT];
        modcfg_d[`FSEF_MODCFG_FDF_BIT] = PWDATA[`FSEF_MODCFG_FDF_BIT];
    end
end

// Error interrupt enables, both plain read and write
always @*
begin
    errcfg_d = errcfg_q;
    if (wr_en && hit_errcfg)
    begin
        errcfg_d[1] = PWDATA[`FSEF_ERRCFG_DF_BIT];
        errcfg_d[0] = PWDATA[`FSEF_ERRCFG_SF_BIT];
    end
end

// Launch needs an idle controller and both error flags clear
assign launch = wr_en && hit_stat && PWDATA[`FSEF_STAT_CC_BIT] && !busy_q
    && !acc_flag // [RL4]
    && !pv_flag; // [RL7]

// A violation ends the running command as completion does
assign cmd_end = CMD_DONE | SEQ_VIOL | ILLEGAL_CMD | PROT_VIOL;

// Busy state; command-complete is its inverse
always @*
begin
    busy_d = busy_q;
    if (launch)
        busy_d = 1'b1; // [RL3]
    else if (cmd_end)
        busy_d = 1'b0; // [RL3] [RL8]
end

// Completion status: cleared at launch, loaded at command or reset end
always @*
begin
    cstat_d = cstat_q;
    if (launch)
        cstat_d = `FSEF_CS_RST;
    else if (CMD_DONE)
        cstat_d = CMD_ERR; // [RL10]
    else if (INIT_DONE)
        cstat_d = INIT_ERR; // [RL10] [RL12]
end

// Sticky flag events and their software clears
assign acc_set = SEQ_VIOL | ILLEGAL_CMD; // [RL4]
assign acc_clr = wr_en && hit_stat && PWDATA[`FSEF_STAT_ACC_BIT]; // [RL5]
assign pv_set = PROT_VIOL; // [RL6]
assign pv_clr = wr_en && hit_stat && PWDATA[`FSEF_STAT_PV_BIT]; // [RL6]

// A forced fault raises the flag on any read; busy block reads are invalid
assign df_set = ARRAY_RD && (RD_DFAULT || RD_BLK_BUSY || force_df); // [RL13] [RL18]
assign df_clr = wr_en && hit_errstat && PWDATA[`FSEF_ERRSTAT_DF_BIT]; // [RL14]
assign sf_set = ARRAY_RD && !ign_sf && (RD_SFAULT || RD_BLK_BUSY); // [RL15] [RL17]
assign sf_clr = wr_en && hit_errstat && PWDATA[`FSEF_ERRSTAT_SF_BIT]; // [RL16]

// Access error flag
fsef_flag u_acc (
    .clk(CLK),
    .rst_n(RST_N),
    .set(acc_set),
    .clr(acc_clr),
    .flag(acc_flag)
);

// Protection violation flag
fsef_flag u_pv (
    .clk(CLK),
    .rst_n(RST_N),
    .set(pv_set),
    .clr(pv_clr),
    .flag(pv_flag)
);

// Double fault flag
fsef_flag u_df (
    .clk(CLK),
    .rst_n(RST_N),
    .set(df_set),
    .clr(df_clr),
    .flag(df_flag)
);

// Single fault flag
fsef_flag u_sf (
    .clk(CLK),
    .rst_n(RST_N),
    .set(sf_set),
    .clr(sf_clr),
    .flag(sf_flag)
);

// Status byte; bit 2 and bit 6 are tied low and never written
assign stat_byte = {
    ~busy_q, // [RL3]
    1'b0,
    acc_flag,
    pv_flag,
    busy_q, // [RL8]
    1'b0, // [RL9]
    cstat_q // [RL11]
};

// Error status byte
assign errstat_byte = {6'h00, df_flag, sf_flag};

// Read data multiplexer; unmapped words read zero
always @*
begin
    case (PADDR[7:2])
        `FSEF_IDX_MODCFG: rd_byte = modcfg_q;
        `FSEF_IDX_ERRCFG: rd_byte = {6'h00, errcfg_q};
        `FSEF_IDX_STAT: rd_byte = stat_byte;
        `FSEF_IDX_ERRSTAT: rd_byte = errstat_byte;
        default: rd_byte = 8'h00;
    endcase
    if (!addr_ok)
        rd_byte = 8'h00;
end

// Read data is captured in the setup cycle so the bus sees a flop
always @*
begin
    prdata_d = prdata_q;
    if (rd_setup)
        prdata_d = {24'h00_0000, rd_byte};
end

// Registers of the block
always @(posedge CLK or negedge RST_N)
begin
    if (!RST_N)
    begin
        modcfg_q <= `FSEF_MODCFG_RST;
        errcfg_q <= 2'h0;
        busy_q <= 1'b0;
        cstat_q <= `FSEF_CS_RST;
        launch_q <= 1'b0;
        ecc_upd_q <= 1'b0;
        prdata_q <= 32'h0000_0000;
    end
    else
    begin
        modcfg_q <= modcfg_d;
        errcfg_q <= errcfg_d;
        busy_q <= busy_d;
        cstat_q <= cstat_d;
        launch_q <= launch; // [RL3]
        // Results update on a real fault only, never on a forced one
        ecc_upd_q <= ARRAY_RD && (RD_DFAULT || (RD_SFAULT && !ign_sf)); // [RL18]
        prdata_q <= prdata_d;
    end
end

// Outputs to the sequencer and read path
assign CMD_LAUNCH = launch_q;
assign SEQ_START_OK = ~pv_flag; // [RL7]
assign ECC_UPDATE = ecc_upd_q;
assign IGNORE_SF = ign_sf;
assign FORCE_DF = force_df;
assign PRDATA = prdata_q;

// Level interrupt; stays high until software clears the flag or its enable bit
assign ERR_IRQ = (df_flag & errcfg_q[1]) // [RL1] [RL19]
    | (sf_flag & errcfg_q[0]); // [RL2] [RL19]

endmodule // fsef_top

/* tb/fsef_top_props.sv */
// Checker for the flash status block, on top-level ports only.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps

module fsef_top_props (
    // Clock and reset
    input wire CLK,
    input wire RST_N,
    // Pins watched
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    input wire PROT_VIOL,
    input wire SEQ_START_OK,
    input wire CMD_LAUNCH,
    input wire ARRAY_RD,
    input wire RD_SFAULT,
    input wire RD_DFAULT,
    input wire IGNORE_SF,
    input wire ECC_UPDATE,
    input wire ERR_IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // Bus answers at once; holes in the map report an error
    AST_READY: assert property (PSEL && PENABLE |-> PREADY)
        else $error("access stalled");
    AST_HOLE: assert property (PSEL && PENABLE && !(PADDR inside {8'h10, 8'h14, 8'h18, 8'h1C})
        |-> PSLVERR)
        else $error("unmapped access not flagged");
    AST_RSVD: assert property (PSEL && !PENABLE && !PWRITE && PADDR == 8'h18
        |=> PRDATA[31:8] == 24'h00_0000 && !PRDATA[2] && !PRDATA[6])
        else $error("reserved status bit set");
    // A violation must block the next sequence and launch
    AST_PVSET: assert property (PROT_VIOL |=> !SEQ_START_OK)
        else $error("violation did not block");
    AST_PVBLK: assert property (!SEQ_START_OK |=> !CMD_LAUNCH)
        else $error("launch while blocked");
    AST_PULSE: assert property (CMD_LAUNCH |=> !CMD_LAUNCH)
        else $error("launch pulse too long");
    // Result update only for genuine faults, never for forced ones
    AST_ECC: assert property (ARRAY_RD && RD_DFAULT |=> ECC_UPDATE)
        else $error("double fault not recorded");
    AST_NOECC: assert property (ARRAY_RD && !RD_DFAULT && (!RD_SFAULT || IGNORE_SF)
        |=> !ECC_UPDATE)
        else $error("spurious result update");
    // Only a bus write can drop the request
    AST_HOLD: assert property (ERR_IRQ && !(PSEL && PENABLE && PWRITE) |=> ERR_IRQ)
        else $error("interrupt dropped");
    AST_COV_LAUNCH: cover property (CMD_LAUNCH);
    AST_COV_IRQ: cover property (ERR_IRQ);
    AST_COV_BLOCK: cover property (!SEQ_START_OK);
endmodule // fsef_top_props

bind fsef_top fsef_top_props u_props (
    .CLK(CLK),
    .RST_N(RST_N),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .PRDATA(PRDATA),
    .PREADY(PREADY),
    .PSLVERR(PSLVERR),
    .PROT_VIOL(PROT_VIOL),
    .SEQ_START_OK(SEQ_START_OK),
    .CMD_LAUNCH(CMD_LAUNCH),
    .ARRAY_RD(ARRAY_RD),
    .RD_SFAULT(RD_SFAULT),
    .RD_DFAULT(RD_DFAULT),
    .IGNORE_SF(IGNORE_SF),
    .ECC_UPDATE(ECC_UPDATE),
    .ERR_IRQ(ERR_IRQ)
);

/* tb/fsef_top_tb.sv */
// Self-checking bench for the flash status and error flag block.
// Assumes a 25 ns clock; sequencer and read events are driven here.
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end

module fsef_top_tb;
    reg CLK = 0;
    reg RST_N = 0;
    reg PSEL = 0, PENABLE = 0, PWRITE = 0;
    reg [7:0] PADDR = 8'h00;
    reg [31:0] PWDATA = 32'h0000_0000;
    reg [3:0] PSTRB = 4'h1;
    reg [1:0] CMD_ERR = 2'h0, INIT_ERR = 2'h0;
    reg [8:0] evt = 9'h000;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, CMD_LAUNCH, SEQ_START_OK, ECC_UPDATE, IGNORE_SF, FORCE_DF, ERR_IRQ;
    integer fail_count = 0, num_checks = 0, launches = 0, ecc_updates = 0;
    reg [31:0] rdat;
    reg perr;

    fsef_top DUT (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .CMD_DONE(evt[8]), .CMD_ERR(CMD_ERR), .SEQ_VIOL(evt[7]),
        .ILLEGAL_CMD(evt[6]), .PROT_VIOL(evt[5]), .INIT_DONE(evt[4]), .INIT_ERR(INIT_ERR),
        .CMD_LAUNCH(CMD_LAUNCH), .SEQ_START_OK(SEQ_START_OK), .ARRAY_RD(evt[3]),
        .RD_SFAULT(evt[2]), .RD_DFAULT(evt[1]), .RD_BLK_BUSY(evt[0]),
        .ECC_UPDATE(ECC_UPDATE), .IGNORE_SF(IGNORE_SF), .FORCE_DF(FORCE_DF), .ERR_IRQ(ERR_IRQ));

    // 40 MHz clock
    initial
    begin
        forever #12.5 CLK = ~CLK;
    end

    // Count launches so a refused one shows as no change
    always @(posedge CLK)
    begin
        if (CMD_LAUNCH === 1'b1)
            launches <= launches + 1;
        if (ECC_UPDATE === 1'b1)
            ecc_updates <= ecc_updates + 1;
    end

    task close_out;
    begin
        if (fail_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask

    // One APB transfer, held until PREADY is seen high
    task apb(input reg is_wr, input reg [7:0] a, input reg [7:0] d);
        integer n;
    begin
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= is_wr;
        PADDR <= a;
        PWDATA <= {24'h00_0000, d};
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do
        begin
            @(posedge CLK);
            n = n + 1;
        end while (PREADY !== 1'b1 && n < 16);
        if (PREADY !== 1'b1)
        begin
            fail_count++;
            close_out;
        end
        rdat = PRDATA;
        perr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        #1;
    end
    endtask

    task wr(input reg [7:0] a, input reg [7:0] d);
    begin
        apb(1'b1, a, d);
    end
    endtask

    task rc(input reg [7:0] a, input reg [7:0] e);
    begin
        apb(1'b0, a, 8'h00);
        `CHK(rdat, {24'h00_0000, e})
    end
    endtask

    // One-cycle event pulse; settles before returning
    task ev(input reg [8:0] v);
    begin
        @(posedge CLK);
        evt <= v;
        @(posedge CLK);
        evt <= 9'h000;
        #1;
    end
    endtask

    task t_reset;
    begin
        rc(8'h18, 8'h80);
        rc(8'h1C, 8'h00);
        apb(1'b0, 8'h40, 8'h00);
        `CHK(perr, 1'b1)
        `CHK(rdat, 32'h0000_0000)
        @(posedge CLK);
        INIT_ERR <= 2'h1;
        ev(9'h010);
        rc(8'h18, 8'h81);
        // A write with the low byte strobe off must be ignored
        @(posedge CLK);
        PSTRB <= 4'h0;
        wr(8'h14, 8'h03);
        @(posedge CLK);
        PSTRB <= 4'h1;
        rc(8'h14, 8'h00);
    end
    endtask

    // Launch, refused relaunch while busy, completion code
    task t_launch;
    begin
        wr(8'h18, 8'hFF);
        rc(8'h18, 8'h08);
        wr(8'h18, 8'h80);
        `CHK(launches, 1)
        @(posedge CLK);
        CMD_ERR <= 2'h2;
        ev(9'h100);
        rc(8'h18, 8'h82);
    end
    endtask

    // Illegal command, then sequence violation
    task t_errors;
        integer i;
    begin
        for (i = 0; i < 2; i++)
        begin
            ev(i ? 9'h080 : 9'h040);
            wr(8'h18, 8'h80);
            wr(8'h18, 8'h00);
            rc(8'h18, 8'hA2);
            wr(8'h18, 8'h20);
            rc(8'h18, 8'h82);
        end
        `CHK(launches, 1)
    end
    endtask

    task t_prot;
    begin
        ev(9'h020);
        `CHK(SEQ_START_OK, 1'b0)
        wr(8'h18, 8'h80);
        wr(8'h18, 8'h00);
        rc(8'h18, 8'h92);
        `CHK(launches, 1)
        wr(8'h18, 8'h10);
        rc(8'h18, 8'h82);
        `CHK(SEQ_START_OK, 1'b1)
    end
    endtask

    task t_faults;
    begin
        wr(8'h14, 8'h03);
        ev(9'h00A);
        `CHK(ERR_IRQ, 1'b1)
        wr(8'h1C, 8'h00);
        rc(8'h1C, 8'h02);
        wr(8'h14, 8'h01);
        `CHK(ERR_IRQ, 1'b0)
        wr(8'h1C, 8'h02);
        ev(9'h00C);
        `CHK(ERR_IRQ, 1'b1)
        wr(8'h1C, 8'h00);
        rc(8'h1C, 8'h01);
        wr(8'h14, 8'h02);
        `CHK(ERR_IRQ, 1'b0)
        wr(8'h1C, 8'h01);
        ev(9'h009);
        rc(8'h1C, 8'h03);
        wr(8'h1C, 8'h03);
    end
    endtask

    task t_modes;
    begin
        wr(8'h10, 8'h10);
        `CHK(IGNORE_SF, 1'b1)
        ev(9'h00C);
        rc(8'h1C, 8'h00);
        wr(8'h10, 8'h02);
        `CHK(FORCE_DF, 1'b1)
        rc(8'h10, 8'h02);
        ev(9'h008);
        rc(8'h1C, 8'h02);
        `CHK(ERR_IRQ, 1'b1)
        rc(8'h14, 8'h02);
        // Only the real double and the real single fault update results
        `CHK(ecc_updates, 2)
    end
    endtask

    initial
    begin
        repeat (10) @(posedge CLK);
        RST_N <= 1'b1;
        t_reset;
        t_launch;
        t_errors;
        t_prot;
        t_faults;
        t_modes;
        close_out;
    end
endmodule // fsef_top_tb
